/* File: common/cps_pkg.sv */
// cell protection sequencer constants and shared types
// assumes a single 125 MHz clock; sample rates derived by divider
package cps_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int SLOW_RATE_HZ = 1;
    localparam int FAST_RATE_HZ = 4;
    localparam int SLOW_SAMPLE_CYCLES = CLK_HZ / SLOW_RATE_HZ;
    localparam int FAST_SAMPLE_CYCLES = CLK_HZ / FAST_RATE_HZ;
    localparam int RUN_LENGTH = 4;
    localparam logic [2:0] RUN_RESET = 3'h0;
    typedef enum logic [2:0] {
        CPS_SLEEP,
        CPS_ON,
        CPS_OFF_OVER,
        CPS_RECTIFY,
        CPS_OFF_UNDER,
        CPS_OFF_CURRENT
    } cps_state_t;
endpackage

/* File: common/cps_tick_if.sv */
// carrier for sample tick and rate select between timer and sequencer
// assumes both ends share the one clock
`timescale 1ns/1ps
interface cps_tick_if;
    logic fast_rate;
    logic sample_tick;
    modport timer (input fast_rate, output sample_tick);
    modport seq (output fast_rate, input sample_tick);
endinterface

/* File: core/cps_sample_timer.sv */
// sample timebase: one-cycle tick at 1 Hz or 4 Hz
// assumes restart pulse from sequencer realigns the interval
`timescale 1ns/1ps
module cps_sample_timer
    import cps_pkg::*;
#(
    parameter int SLOW_CYCLES = SLOW_SAMPLE_CYCLES,
    parameter int FAST_CYCLES = FAST_SAMPLE_CYCLES
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic restart,
    cps_tick_if.timer tick
);
    initial
    begin
        if (FAST_CYCLES < 2 || SLOW_CYCLES < FAST_CYCLES)
            $error("cps_sample_timer: bad interval parameters");
    end
    typedef struct packed {
        logic [31:0] count;
        logic tick;
    } cps_timer_t;
    cps_timer_t r;
    cps_timer_t next_r;
    logic [31:0] limit;
    always_comb
    begin
        limit = tick.fast_rate ? 32'(FAST_CYCLES - 1) : 32'(SLOW_CYCLES - 1);
        next_r = r;
        next_r.tick = 1'b0;
        if (restart)
            next_r.count = 32'h0000_0000;
        // >= so a switch to the short interval takes effect at once
        else if (r.count >= limit)
        begin
            next_r.count = 32'h0000_0000;
            next_r.tick = 1'b1;
        end
        else
            next_r.count = r.count + 32'h0000_0001;
    end
    always_ff @(posedge clock)
    begin
        if (srst)
            r <= '0;
        else
            r <= next_r;
    end
    assign tick.sample_tick = r.tick;
endmodule

/* File: core/cps_sequencer.sv */
// cell protection sequencer: sampled fault handling and gate control
// assumes comparator and detector levels arrive asynchronously from
// the analog front end and are synchronised here
`timescale 1ns/1ps
module cps_sequencer
    import cps_pkg::*;
#(
    parameter int SLOW_CYCLES = SLOW_SAMPLE_CYCLES,
    parameter int FAST_CYCLES = FAST_SAMPLE_CYCLES,
    parameter int RUN_COUNT = RUN_LENGTH
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic enable_pin,
    input wire logic above_upper_cell_limit,
    input wire logic below_lower_cell_limit,
    input wire logic above_safety_cell_limit,
    input wire logic load_detect,
    input wire logic charger_detect,
    input wire logic discharge_overcurrent,
    input wire logic high_impedance_detect,
    output logic switch_a_on,
    output logic switch_b_on,
    output logic rectification_bias,
    output logic cell_bypass_on,
    output logic overcharge_flag,
    output logic fast_sampling,
    output logic sleep_mode
);
    initial
    begin
        if (RUN_COUNT < 1 || RUN_COUNT > 7)
            $error("cps_sequencer: RUN_COUNT must be 1 to 7");
    end

    // ************************************************
    // input synchronisers
    // ************************************************
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    assign raw_in = {enable_pin, above_upper_cell_limit, below_lower_cell_limit,
        above_safety_cell_limit, load_detect, charger_detect,
        discharge_overcurrent, high_impedance_detect};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge clock)
            begin
                if (srst)
                begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end
                else
                begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate
    logic en_s, over_s, under_s, safe_s, load_s, chg_s, ocur_s, himp_s;
    assign {en_s, over_s, under_s, safe_s, load_s, chg_s, ocur_s, himp_s} = sync_b;

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        cps_state_t state;
        logic [2:0] over_run;
        logic [2:0] under_run;
        logic [2:0] good_run;
        logic en_prev;
        logic fast;
        logic gate_a;
        logic gate_b;
        logic bias;
        logic bypass;
        logic hold;
        logic sleep;
    } cps_seq_t;
    cps_seq_t r;
    cps_seq_t next_r;
    logic restart;
    cps_tick_if tick_bus ();

    cps_sample_timer #(
        .SLOW_CYCLES(SLOW_CYCLES),
        .FAST_CYCLES(FAST_CYCLES)
    ) u_timer (
        .clock(clock),
        .srst(srst),
        .restart(restart),
        .tick(tick_bus.timer)
    );
    assign tick_bus.fast_rate = r.fast;

    function automatic logic [2:0] run_step(input logic [2:0] run, input logic hit);
        // a failing sample restarts the run; saturates at the target
        if (!hit)
            run_step = RUN_RESET;
        else if (run >= 3'(RUN_COUNT))
            run_step = run;
        else
            run_step = run + 3'h1;
    endfunction

    localparam logic [2:0] RUN_TOP = 3'(RUN_COUNT);
    logic sample;
    logic [2:0] over_nx, under_nx, good_nx;
    always_comb
    begin
        sample = tick_bus.sample_tick;
        over_nx = run_step(r.over_run, over_s);
        under_nx = run_step(r.under_run, under_s);
        good_nx = run_step(r.good_run, !over_s);
        next_r = r;
        next_r.en_prev = en_s;
        restart = 1'b0;
        if (sample)
        begin
            next_r.over_run = over_nx;
            next_r.under_run = under_nx;
            next_r.good_run = good_nx;
            if (over_s)
                next_r.fast = 1'b1;
            else if (good_nx == RUN_TOP)
                next_r.fast = 1'b0;
            if (!over_s)
                next_r.bypass = 1'b0;
        end
        if (!en_s)
        begin
            // sleep: pair off, history kept clear for the next wake-up
            next_r.state = CPS_SLEEP;
            next_r.over_run = RUN_RESET;
            next_r.under_run = RUN_RESET;
            next_r.good_run = RUN_RESET;
            next_r.fast = 1'b0;
            next_r.bypass = 1'b0;
        end
        else if (!r.en_prev)
        begin
            // rising edge: gate restored, sample memory cleared
            next_r.state = CPS_ON;
            next_r.over_run = RUN_RESET;
            next_r.under_run = RUN_RESET;
            next_r.good_run = RUN_RESET;
            next_r.fast = 1'b0;
            restart = 1'b1;
        end
        else
        begin
            case (r.state)
                CPS_ON:
                begin
                    if (sample && (safe_s || over_nx == RUN_TOP))
                    begin
                        // safety sample trips at once; on-time then is up to one interval at the current rate
                        next_r.state = CPS_OFF_OVER;
                        next_r.bypass = 1'b1;
                        next_r.good_run = RUN_RESET;
                        next_r.hold = 1'b0;
                    end
                    else if (sample && under_nx == RUN_TOP)
                        next_r.state = CPS_OFF_UNDER;
                end
                CPS_OFF_OVER:
                begin
                    // after a load-removal cut, full drive waits for a whole good run
                    if (load_s && over_s)
                        next_r.state = CPS_RECTIFY;
                    else if (sample && !over_s && (!r.hold || good_nx == RUN_TOP))
                        next_r.state = CPS_ON;
                end
                CPS_RECTIFY:
                begin
                    if (ocur_s)
                    begin
                        next_r.state = CPS_OFF_CURRENT;
                        next_r.good_run = RUN_RESET;
                    end
                    else if (sample && good_nx == RUN_TOP)
                        next_r.state = CPS_ON;
                    else if (!load_s)
                    begin
                        next_r.state = CPS_OFF_OVER;
                        next_r.hold = 1'b1;
                    end
                end
                CPS_OFF_UNDER:
                begin
                    if (chg_s)
                        next_r.state = CPS_ON;
                end
                CPS_OFF_CURRENT:
                begin
                    // on return the normal supervision takes over the load
                    if (himp_s || (sample && good_nx == RUN_TOP))
                        next_r.state = CPS_ON;
                end
                CPS_SLEEP:
                    next_r.state = CPS_SLEEP;
                default:
                    next_r.state = CPS_SLEEP;
            endcase
        end
        // two separate enables, both decoded the same way from the state
        next_r.gate_a = (next_r.state == CPS_ON) || (next_r.state == CPS_RECTIFY);
        next_r.gate_b = (next_r.state == CPS_ON) || (next_r.state == CPS_RECTIFY);
        next_r.bias = (next_r.state == CPS_RECTIFY);
        next_r.sleep = (next_r.state == CPS_SLEEP);
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            r <= '0;
            r.state <= CPS_SLEEP;
            r.sleep <= 1'b1;
        end
        else
            r <= next_r;
    end

    // ************************************************
    // outputs, all registered
    // ************************************************
    assign switch_a_on = r.gate_a;
    assign switch_b_on = r.gate_b;
    assign rectification_bias = r.bias;
    assign cell_bypass_on = r.bypass;
    assign overcharge_flag = r.bypass;
    assign fast_sampling = r.fast;
    assign sleep_mode = r.sleep;
endmodule

/* File: tb/cps_seq_asserts.sv */
// assertion checker for the cell protection sequencer ports
// assumes a bind onto cps_sequencer, which hands on its fast interval
`timescale 1ns/1ps
module cps_seq_asserts
    import cps_pkg::*;
#(
    parameter int FAST_CYCLES = FAST_SAMPLE_CYCLES
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic enable_pin,
    input wire logic load_detect,
    input wire logic switch_a_on,
    input wire logic switch_b_on,
    input wire logic rectification_bias,
    input wire logic cell_bypass_on,
    input wire logic overcharge_flag,
    input wire logic fast_sampling,
    input wire logic sleep_mode
);
    // ************************************************************
    // helper: cycles spent at the fast rate
    // ************************************************************
    int fast_len;
    always_ff @(posedge clock)
    begin
        fast_len <= (srst || !fast_sampling) ? 0 : fast_len + 1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    chk_pair_agree: assert property (switch_a_on == switch_b_on)
        else $error("switch enables disagree");
    chk_sleep_off: assert property (sleep_mode |-> !switch_a_on && !switch_b_on)
        else $error("pair on in sleep");
    chk_enable_low_sleep: assert property (!enable_pin [*4] |-> sleep_mode)
        else $error("no sleep with enable low");
    chk_enable_rise_on: assert property ($rose(enable_pin) ##1 enable_pin [*4]
        |-> switch_a_on && !sleep_mode)
        else $error("enable rise did not restore gate");
    chk_flag_bypass: assert property (overcharge_flag == cell_bypass_on)
        else $error("indicator and bypass differ");
    chk_bypass_off_pair: assert property ($rose(cell_bypass_on) |-> !switch_a_on)
        else $error("bypass connected with pair on");
    chk_bias_pair_on: assert property (rectification_bias |-> switch_a_on && switch_b_on)
        else $error("bias without conduction");
    chk_bias_load: assert property (rectification_bias |-> $past(load_detect, 2)
        || $past(load_detect, 3) || $past(load_detect, 4))
        else $error("bias without load");
    chk_fast_hold: assert property ($fell(fast_sampling) |-> sleep_mode
        || $past(sleep_mode) || fast_len >= 3 * FAST_CYCLES)
        else $error("fast rate dropped early");
endmodule
bind cps_sequencer cps_seq_asserts #(.FAST_CYCLES(FAST_CYCLES)) i_chk (.clock(clock),
    .srst(srst), .enable_pin(enable_pin), .load_detect(load_detect),
    .switch_a_on(switch_a_on), .switch_b_on(switch_b_on),
    .rectification_bias(rectification_bias), .cell_bypass_on(cell_bypass_on),
    .overcharge_flag(overcharge_flag), .fast_sampling(fast_sampling), .sleep_mode(sleep_mode));

/* File: tb/cps_cell_model.sv */
// far side model: the cell, a charger and a load at the pack terminals
// assumes comparator levels follow the cell voltage without noise
`timescale 1ns/1ps
module cps_cell_model
#(
    parameter int UPPER_MV = 4200,
    parameter int LOWER_MV = 2400
)
(
    input wire logic [15:0] cell_mv,
    input wire logic load_on,
    input wire logic heavy_load,
    input wire logic charger_on,
    output logic above_upper_cell_limit,
    output logic below_lower_cell_limit,
    output logic above_safety_cell_limit,
    output logic load_detect,
    output logic charger_detect,
    output logic discharge_overcurrent,
    output logic high_impedance_detect
);
    // ************************************************************
    // comparators and terminal detectors
    // ************************************************************
    assign above_upper_cell_limit = int'(cell_mv) > UPPER_MV;
    assign below_lower_cell_limit = int'(cell_mv) < LOWER_MV;
    // safety limit sits 100 mV over the upper limit
    assign above_safety_cell_limit = int'(cell_mv) > UPPER_MV + 100;
    assign load_detect = load_on | heavy_load;
    assign charger_detect = charger_on;
    assign discharge_overcurrent = heavy_load;
    // open terminals only when nothing at all is attached
    assign high_impedance_detect = ~(load_on | heavy_load | charger_on);
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the cell protection sequencer
// assumes shortened sample intervals of 40 and 10 cycles
`timescale 1ns/1ps
module tb_top;
    import cps_pkg::*;
    localparam int SLOW = 40;
    localparam int FAST = 10;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic enable_pin = 1'b0;
    logic [15:0] cell_mv = 16'h0ea6;
    logic load_on = 1'b0;
    logic heavy_load = 1'b0;
    logic charger_on = 1'b0;
    logic up, low, safe, ld, chg, oc, hz;
    logic sw_a, sw_b, bias, bypass, flag, fast, sleep;
    int num_errors = 0;
    int num_checks = 0;
    // ************************************************************
    // design, far side and shared tasks
    // ************************************************************
    cps_cell_model i_cell (.cell_mv(cell_mv), .load_on(load_on), .heavy_load(heavy_load),
        .charger_on(charger_on), .above_upper_cell_limit(up), .below_lower_cell_limit(low),
        .above_safety_cell_limit(safe), .load_detect(ld), .charger_detect(chg),
        .discharge_overcurrent(oc), .high_impedance_detect(hz));
    cps_sequencer #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST), .RUN_COUNT(RUN_LENGTH)) i_dut (
        .clock(clock), .srst(srst), .enable_pin(enable_pin), .above_upper_cell_limit(up),
        .below_lower_cell_limit(low), .above_safety_cell_limit(safe), .load_detect(ld),
        .charger_detect(chg), .discharge_overcurrent(oc), .high_impedance_detect(hz),
        .switch_a_on(sw_a), .switch_b_on(sw_b), .rectification_bias(bias),
        .cell_bypass_on(bypass), .overcharge_flag(flag), .fast_sampling(fast),
        .sleep_mode(sleep));
    initial
    begin
        forever #4 clock = ~clock;
    end
    task automatic check(input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // bounded wait on the switch enable (k=0) or the fast rate (k=1)
    task automatic wait_on(input int k, input logic exp, input int max);
        int n = 0;
        while ((k ? fast : sw_a) !== exp && n < max)
        begin
            cyc(1);
            n++;
        end
        check(k ? fast : sw_a, exp);
    endtask
    task automatic final_report;
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic s_wake;
        check(sleep & ~sw_a & ~sw_b, 1'b1);
        enable_pin = 1'b1;
        cyc(5);
        check(sw_a & sw_b & ~sleep, 1'b1);
    endtask
    task automatic s_over;
        cell_mv = 16'h109a;
        wait_on(1, 1'b1, SLOW + 8);
        cyc(25);
        check(sw_a, 1'b1);
        cyc(10);
        check(sw_a, 1'b0);
        check(bypass & flag, 1'b1);
        cell_mv = 16'h1004;
        wait_on(0, 1'b1, FAST + 8);
        check(bypass | flag, 1'b0);
        cyc(2 * FAST);
        check(fast, 1'b1);
        cyc(3 * FAST);
        check(fast, 1'b0);
    endtask
    task automatic s_safety;
        cell_mv = 16'h10fe;
        wait_on(1, 1'b1, SLOW + 8);
        cyc(2);
        check(sw_a, 1'b0);
        cell_mv = 16'h1004;
        wait_on(0, 1'b1, FAST + 8);
        cell_mv = 16'h10fe;
        wait_on(0, 1'b0, FAST + 4);
        cyc(4 * FAST);
        check(sw_a, 1'b0);
        charger_on = 1'b1;
        cyc(FAST + 4);
        check(sw_a, 1'b0);
        charger_on = 1'b0;
    endtask
    task automatic s_rectify;
        cell_mv = 16'h109a;
        cyc(2 * FAST);
        load_on = 1'b1;
        wait_on(0, 1'b1, FAST + 8);
        check(bias, 1'b1);
        load_on = 1'b0;
        wait_on(0, 1'b0, FAST + 8);
        // two good samples after the cut must not restore full drive
        cell_mv = 16'h1004;
        cyc(2 * FAST);
        check(sw_a, 1'b0);
        cell_mv = 16'h109a;
        load_on = 1'b1;
        wait_on(0, 1'b1, FAST + 8);
        heavy_load = 1'b1;
        wait_on(0, 1'b0, FAST + 8);
        // overcurrent load kept on: recovery by four good samples
        cell_mv = 16'h1004;
        cyc(2 * FAST);
        check(sw_a, 1'b0);
        wait_on(0, 1'b1, 3 * FAST);
        cell_mv = 16'h10fe;
        wait_on(0, 1'b0, SLOW + 8);
        cyc(4);
        check(sw_a, 1'b0);
        load_on = 1'b0;
        heavy_load = 1'b0;
        wait_on(0, 1'b1, FAST + 8);
    endtask
    task automatic s_under;
        enable_pin = 1'b0;
        cyc(5);
        check(sleep & ~sw_a, 1'b1);
        cell_mv = 16'h07d0;
        enable_pin = 1'b1;
        cyc(4 * SLOW - 8);
        check(sw_a, 1'b1);
        wait_on(0, 1'b0, SLOW);
        cell_mv = 16'h0bb8;
        cyc(2 * SLOW);
        check(sw_a, 1'b0);
        charger_on = 1'b1;
        wait_on(0, 1'b1, SLOW + 8);
    endtask
    initial
    begin
        cyc(6);
        srst = 1'b0;
        cyc(2);
        s_wake();
        s_over();
        s_safety();
        s_rectify();
        s_under();
        final_report();
    end
    initial
    begin
        #(8 * 5000);
        num_errors++;
        final_report();
    end
endmodule
